// ---- cip_map.svh ----
// Purpose: Offsets, field positions, reset values and codes of the charger register port.
// Assumes: Included by its bare name wherever a constant is needed.
// Notes:   Definitions only; no logic lives here.
`ifndef CIP_MAP_SVH
`define CIP_MAP_SVH

// Seven-bit target address on the two-wire bus
`define CIP_TARGET_ADDR   7'h6B
// Register indices
`define CIP_REG_SRC       8'h00
`define CIP_REG_FAULT     8'h09
`define CIP_REG_LAST      8'h0B
// Byte returned for any index above the last register
`define CIP_EMPTY_READ    8'hFF
// Input-source control fields
`define CIP_HIGH_IMP_BIT  7
`define CIP_STAT_MSB      6
`define CIP_STAT_LSB      5
`define CIP_LIM_MSB       4
`define CIP_LIM_LSB       0
// Status-pin function codes
`define CIP_STAT_ENABLE   2'h0
`define CIP_STAT_OFF      2'h3
// Reset values
`define CIP_HIGH_IMP_RESET 1'h0
`define CIP_LIM_RESET     5'h17
`define CIP_SRC_RESET     8'h17
`define CIP_OTHER_RESET   8'h00
// Input current limit codes: (mA - 100) / 100
`define CIP_LIM_500MA     5'h04
`define CIP_LIM_1000MA    5'h09
`define CIP_LIM_2000MA    5'h13
`define CIP_LIM_2100MA    5'h14
`define CIP_LIM_2400MA    5'h17
// Fault register layout: latched bits 7:3, live thermistor bits 2:0
`define CIP_FLT_LATCH_MSB 7
`define CIP_FLT_LATCH_LSB 3
`define CIP_FLT_THERM_MSB 2
// Bit count of one byte on the wire
`define CIP_BYTE_BITS     4'h8

`endif

// ---- cip_pkg.sv ----
// Purpose: Types shared by the charger register port modules.
// Assumes: Constants come from cip_map.svh.
// Notes:   Nothing here is imported; users write cip_pkg::name.
package cip_pkg;

  // Serial engine states, Gray coded along the usual path except CIP_A_ACK to CIP_RD
  typedef enum logic [3:0] {
    CIP_IDLE  = 4'h0,
    CIP_ADDR  = 4'h1,
    CIP_A_ACK = 4'h3,
    CIP_INDEX = 4'h2,
    CIP_I_ACK = 4'h6,
    CIP_WR    = 4'h7,
    CIP_W_ACK = 4'h5,
    CIP_RD    = 4'h4,
    CIP_M_ACK = 4'hC
  } cip_state_type;

  // Source kinds reported by input source detection
  typedef enum logic [2:0] {
    CIP_SRC_STD_PORT = 3'h0,
    CIP_SRC_CHG_PORT = 3'h1,
    CIP_SRC_UNKNOWN = 3'h2,
    CIP_SRC_NS1A    = 3'h3,
    CIP_SRC_NS2A    = 3'h4,
    CIP_SRC_NS21A   = 3'h5,
    CIP_SRC_NS24A   = 3'h6
  } cip_src_type;

  // Synchronised pins sampled on the system clock
  typedef struct packed {
    logic psel;   // Source-select strap pin
    logic sda;    // Serial data
    logic scl;    // Serial clock
  } cip_pins_type;

  // Whole state of the port
  typedef struct packed {
    cip_state_type     state;      // Serial engine state
    logic              scl_q;      // Last synced clock level
    logic              sda_q;      // Last synced data level
    logic [3:0]        cnt;        // Bits seen in the current byte
    logic [7:0]        shift;      // Incoming byte
    logic [7:0]        tx;         // Outgoing byte
    logic              rw;         // Direction bit of the address
    logic              first;      // Next data byte is the first of the transfer
    logic [7:0]        ptr;        // Register pointer
    logic              sda_oe;     // Drive data line low
    logic              sda_o;      // Data level when driven, always low
    logic [11:0][7:0]  bank;       // Register bank, index 9 unused
    logic [4:0]        flt;        // Latched fault bits
    logic              armed;      // Fault interrupt allowed
    logic              int_pulse;  // Fault interrupt output
  } cip_st_type;

endpackage

// ---- cip_sync.sv ----
// Purpose: Two-stage synchroniser for pins entering the system clock domain.
// Assumes: Clock enable freezes both stages.
// Notes:   First stage feeds only the second.
`timescale 1ns/10ps
module cip_sync (
  input  wire logic                 i_mclk,
  input  wire logic                 i_reset,
  input  wire logic                 i_ce,
  input  wire cip_pkg::cip_pins_type i_pins,
  output      cip_pkg::cip_pins_type o_pins
);

  // First and second stages; idle bus levels are high
  cip_pkg::cip_pins_type meta_r;
  cip_pkg::cip_pins_type sync_r;

  // Two flops per pin to settle metastability
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      meta_r <= 3'h3;
      sync_r <= 3'h3;
    end else if (i_ce) begin
      meta_r <= i_pins;
      sync_r <= meta_r;
    end
  end

  assign o_pins = sync_r;

endmodule

// ---- cip_limit.sv ----
// Purpose: Maps the detected input source to an input current limit code.
// Assumes: Detection result is stable when the done pulse arrives.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/10ps
`include "cip_map.svh"
module cip_limit (
  input  wire logic                i_variant_det,
  input  wire logic                i_psel,
  input  wire cip_pkg::cip_src_type i_src,
  output      logic [4:0]          o_code
);

  // Limit code for the detection variant
  function automatic logic [4:0] det_code(input cip_pkg::cip_src_type src);
    case (src)
      cip_pkg::CIP_SRC_STD_PORT: det_code = `CIP_LIM_500MA;
      cip_pkg::CIP_SRC_CHG_PORT: det_code = `CIP_LIM_2400MA;
      cip_pkg::CIP_SRC_NS1A:    det_code = `CIP_LIM_1000MA;
      cip_pkg::CIP_SRC_NS2A:    det_code = `CIP_LIM_2000MA;
      cip_pkg::CIP_SRC_NS21A:   det_code = `CIP_LIM_2100MA;
      cip_pkg::CIP_SRC_NS24A:   det_code = `CIP_LIM_2400MA;
      // Unknown adapters get the safe USB figure
      default:                  det_code = `CIP_LIM_500MA;
    endcase
  endfunction

  // Select by variant; strap high means USB-class source
  always_comb begin
    if (i_variant_det) begin
      o_code = det_code(i_src);
    end else begin
      o_code = i_psel ? `CIP_LIM_500MA : `CIP_LIM_2400MA;
    end
  end

endmodule

// ---- cip_port.sv ----
// Purpose: Two-wire target port giving the host access to the charger register bank.
// Assumes: Host drives the serial clock; no clock stretching is done here.
// Notes:   Serial pins are sampled on i_mclk; SCL must stay well below mclk/8.
`timescale 1ns/10ps
`include "cip_map.svh"
module cip_port (
  input  wire logic                i_mclk,
  input  wire logic                i_reset,
  input  wire logic                i_ce,
  input  wire logic                i_scl,
  input  wire logic                i_sda,
  output      logic                o_sda,
  output      logic                o_sda_oe,
  input  wire logic                i_reg_reset,
  input  wire logic                i_wdog_expire,
  input  wire logic [4:0]          i_fault,
  input  wire logic [2:0]          i_therm_fault,
  input  wire logic                i_det_done,
  input  wire logic                i_variant_det,
  input  wire cip_pkg::cip_src_type i_det_src,
  input  wire logic                i_psel,
  output      logic                o_high_impedance_enable,
  output      logic [1:0]          o_stat_func,
  output      logic [4:0]          o_iin_limit,
  output      logic                o_fault_int
);

  cip_pkg::cip_pins_type pins_raw;   // Pins before synchronising
  cip_pkg::cip_pins_type pins;       // Pins after synchronising
  logic [4:0]            auto_code;  // Limit picked by source detection
  cip_pkg::cip_st_type   st_r;       // Registered state
  cip_pkg::cip_st_type   st_nxt;     // Next state

  // True for a register index that exists
  function automatic logic reg_defined(input logic [7:0] idx);
    reg_defined = (idx <= `CIP_REG_LAST);
  endfunction

  // Byte that a read of an index returns; fault bits merged with live thermistor
  function automatic logic [7:0] reg_value(input cip_pkg::cip_st_type s,
                                           input logic [7:0] idx,
                                           input logic [2:0] therm);
    if (!reg_defined(idx)) begin
      reg_value = `CIP_EMPTY_READ;
    end else if (idx == `CIP_REG_FAULT) begin
      reg_value = {s.flt, therm};
    end else begin
      reg_value = s.bank[idx[3:0]];
    end
  endfunction

  assign pins_raw = '{psel: i_psel, sda: i_sda, scl: i_scl};

  // Pin synchroniser
  cip_sync u_sync (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_ce    (i_ce),
    .i_pins  (pins_raw),
    .o_pins  (pins)
  );

  // Automatic limit lookup
  cip_limit u_limit (
    .i_variant_det (i_variant_det),
    .i_psel        (pins.psel),
    .i_src         (i_det_src),
    .o_code        (auto_code)
  );

  // Next-state logic: serial engine, register bank, fault latch
  always_comb begin
    logic       scl_rise;
    logic       scl_fall;
    logic       start_c;
    logic       stop_c;
    logic       flt_clear;
    logic [4:0] flt_new;
    scl_rise  = 1'b0;
    scl_fall  = 1'b0;
    start_c   = 1'b0;
    stop_c    = 1'b0;
    flt_clear = 1'b0;
    flt_new   = 5'h00;
    st_nxt    = st_r;
    scl_rise  = pins.scl & ~st_r.scl_q;
    scl_fall  = ~pins.scl & st_r.scl_q;
    // Data edges while clock high mark start and stop
    start_c   = pins.scl & st_r.scl_q & st_r.sda_q & ~pins.sda;
    stop_c    = pins.scl & st_r.scl_q & ~st_r.sda_q & pins.sda;
    st_nxt.scl_q     = pins.scl;
    st_nxt.sda_q     = pins.sda;
    st_nxt.sda_o     = 1'b0;
    st_nxt.int_pulse = 1'b0;

    if (start_c) begin
      // Start or repeated start: receive an address
      st_nxt.state  = cip_pkg::CIP_ADDR;
      st_nxt.cnt    = 4'h0;
      st_nxt.sda_oe = 1'b0;
    end else if (stop_c) begin
      // Stop frees the bus
      st_nxt.state  = cip_pkg::CIP_IDLE;
      st_nxt.sda_oe = 1'b0;
    end else begin
      // Shift in one bit on each rising clock until eight are counted, whatever the state
      if (scl_rise && st_r.cnt < `CIP_BYTE_BITS) begin
        st_nxt.shift = {st_r.shift[6:0], pins.sda};
        st_nxt.cnt   = st_r.cnt + 4'h1;
      end
      case (st_r.state)
        cip_pkg::CIP_IDLE: begin
          st_nxt.sda_oe = 1'b0;
        end
        cip_pkg::CIP_ADDR: begin
          if (scl_fall && st_r.cnt == `CIP_BYTE_BITS) begin
            if (st_r.shift[7:1] == `CIP_TARGET_ADDR) begin
              st_nxt.sda_oe = 1'b1;
              st_nxt.rw     = st_r.shift[0];
              st_nxt.first  = 1'b1;
              st_nxt.state  = cip_pkg::CIP_A_ACK;
            end else begin
              st_nxt.state = cip_pkg::CIP_IDLE;
            end
          end
        end
        cip_pkg::CIP_A_ACK: begin
          if (scl_fall) begin
            st_nxt.cnt = 4'h0;
            if (st_r.rw) begin
              // First read byte goes out at once
              st_nxt.tx     = reg_value(st_r, st_r.ptr, i_therm_fault);
              st_nxt.sda_oe = ~st_nxt.tx[7];
              // single fault read clears the latch
              flt_clear     = (st_r.ptr == `CIP_REG_FAULT);
              st_nxt.ptr    = st_r.ptr + 8'h01;
              st_nxt.first  = 1'b0;
              st_nxt.state  = cip_pkg::CIP_RD;
            end else begin
              st_nxt.sda_oe = 1'b0;
              st_nxt.state  = cip_pkg::CIP_INDEX;
            end
          end
        end
        cip_pkg::CIP_INDEX: begin
          if (scl_fall && st_r.cnt == `CIP_BYTE_BITS) begin
            if (reg_defined(st_r.shift)) begin
              st_nxt.ptr    = st_r.shift;
              st_nxt.sda_oe = 1'b1;
              st_nxt.state  = cip_pkg::CIP_I_ACK;
            end else begin
              st_nxt.state  = cip_pkg::CIP_IDLE;
            end
          end
        end
        cip_pkg::CIP_I_ACK, cip_pkg::CIP_W_ACK: begin
          if (scl_fall) begin
            st_nxt.sda_oe = 1'b0;
            st_nxt.cnt    = 4'h0;
            st_nxt.state  = cip_pkg::CIP_WR;
          end
        end
        cip_pkg::CIP_WR: begin
          if (scl_fall && st_r.cnt == `CIP_BYTE_BITS) begin
            // burst write while in range, else refusal
            if (reg_defined(st_r.ptr)) begin
              if (st_r.ptr != `CIP_REG_FAULT) begin
                // a host write to index 0 replaces the automatic limit
                st_nxt.bank[st_r.ptr[3:0]] = st_r.shift;
              end
              st_nxt.ptr    = st_r.ptr + 8'h01;
              st_nxt.sda_oe = 1'b1;
              st_nxt.state  = cip_pkg::CIP_W_ACK;
            end else begin
              st_nxt.state  = cip_pkg::CIP_IDLE;
            end
          end
        end
        cip_pkg::CIP_RD: begin
          if (scl_fall) begin
            if (st_r.cnt == `CIP_BYTE_BITS) begin
              // Release for the host acknowledge
              st_nxt.sda_oe = 1'b0;
              st_nxt.state  = cip_pkg::CIP_M_ACK;
            end else begin
              st_nxt.tx     = {st_r.tx[6:0], 1'b1};
              st_nxt.sda_oe = ~st_r.tx[6];
            end
          end
        end
        cip_pkg::CIP_M_ACK: begin
          if (scl_rise && pins.sda) begin
            // Host said no more; wait for stop or start
            st_nxt.state = cip_pkg::CIP_IDLE;
          end else if (scl_fall) begin
            // burst read continues at the next index
            st_nxt.cnt = 4'h0;
            if (st_r.ptr == `CIP_REG_FAULT) begin
              // no clear inside a burst; latched bits with live thermistor bits
              st_nxt.tx = {st_r.flt, i_therm_fault};
            end else begin
              st_nxt.tx = reg_value(st_r, st_r.ptr, i_therm_fault);
            end
            st_nxt.sda_oe = ~st_nxt.tx[7];
            st_nxt.ptr    = st_r.ptr + 8'h01;
            st_nxt.state  = cip_pkg::CIP_RD;
          end
        end
        default: begin
          st_nxt.state  = cip_pkg::CIP_IDLE;
          st_nxt.sda_oe = 1'b0;
        end
      endcase
    end

    // detection done loads the automatic limit
    if (i_det_done) begin
      st_nxt.bank[0][`CIP_LIM_MSB:`CIP_LIM_LSB] = auto_code;
    end

    if (i_wdog_expire) begin
      st_nxt.bank[0][`CIP_HIGH_IMP_BIT] = `CIP_HIGH_IMP_RESET;
    end

    // register reset restores the whole bank
    if (i_reg_reset) begin
      st_nxt.bank    = {12{`CIP_OTHER_RESET}};
      st_nxt.bank[0] = `CIP_SRC_RESET;
    end

    // latch faults; new events win over a read clear
    flt_new    = i_fault & ~st_r.flt;
    st_nxt.flt = (flt_clear ? 5'h00 : st_r.flt) | i_fault;
    // one pulse, re-armed only by a read leaving nothing set
    if (st_r.armed && (|flt_new)) begin
      st_nxt.int_pulse = 1'b1;
      st_nxt.armed     = 1'b0;
    end else if (flt_clear && !(|i_fault)) begin
      st_nxt.armed = 1'b1;
    end
  end

  // State register; clock enable freezes everything
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      st_r           <= '0;
      st_r.state     <= cip_pkg::CIP_IDLE;
      st_r.scl_q     <= 1'b1;
      st_r.sda_q     <= 1'b1;
      st_r.bank      <= {12{`CIP_OTHER_RESET}};
      st_r.bank[0]   <= `CIP_SRC_RESET;
      st_r.armed     <= 1'b1;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from state flops
  assign o_sda       = st_r.sda_o;
  assign o_sda_oe    = st_r.sda_oe;
  assign o_high_impedance_enable = st_r.bank[0][`CIP_HIGH_IMP_BIT];
  assign o_stat_func = st_r.bank[0][`CIP_STAT_MSB:`CIP_STAT_LSB];
  // code n means (n+1) x 100 mA
  assign o_iin_limit = st_r.bank[0][`CIP_LIM_MSB:`CIP_LIM_LSB];
  assign o_fault_int = st_r.int_pulse;

endmodule

// ---- cip_port_properties.sv ----
// Purpose: Concurrent checks on the pins of the charger register port.
// Assumes: Bound to cip_port; one clock domain, reset asynchronous high.
// Notes:   Bus timing is judged on raw pins, which lead the synced copies.
`timescale 1ns/10ps
`include "cip_map.svh"
module cip_port_chk (
  input wire logic                 i_mclk,
  input wire logic                 i_reset,
  input wire logic                 i_ce,
  input wire logic                 i_scl,
  input wire logic                 i_sda,
  input wire logic                 o_sda,
  input wire logic                 o_sda_oe,
  input wire logic                 i_reg_reset,
  input wire logic                 i_wdog_expire,
  input wire logic [4:0]           i_fault,
  input wire logic [2:0]           i_therm_fault,
  input wire logic                 i_det_done,
  input wire logic                 i_variant_det,
  input wire cip_pkg::cip_src_type i_det_src,
  input wire logic                 i_psel,
  input wire logic                 o_high_impedance_enable,
  input wire logic [1:0]           o_stat_func,
  input wire logic [4:0]           o_iin_limit,
  input wire logic                 o_fault_int
);
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (i_reset);

  // Limit expected after detection; own table so a shared slip is not masked
  function automatic logic [4:0] lim_of(input cip_pkg::cip_src_type s);
    case (s)
      cip_pkg::CIP_SRC_STD_PORT: return `CIP_LIM_500MA;
      cip_pkg::CIP_SRC_UNKNOWN: return `CIP_LIM_500MA;
      cip_pkg::CIP_SRC_NS1A:    return `CIP_LIM_1000MA;
      cip_pkg::CIP_SRC_NS2A:    return `CIP_LIM_2000MA;
      cip_pkg::CIP_SRC_NS21A:   return `CIP_LIM_2100MA;
      default:                  return `CIP_LIM_2400MA;
    endcase
  endfunction

  chk_regrst_fields: assert property (i_reg_reset && i_ce |=>
    o_iin_limit == `CIP_LIM_RESET && o_stat_func == `CIP_STAT_ENABLE
    && !o_high_impedance_enable)
    else $error("register reset left input control fields set");
  chk_wdog_high_imp: assert property (i_wdog_expire && i_ce |=> !o_high_impedance_enable)
    else $error("watchdog did not clear high impedance enable");
  chk_wdog_keep: assert property (i_wdog_expire && !i_reg_reset && !i_det_done
    |=> $stable(o_iin_limit) && $stable(o_stat_func))
    else $error("watchdog disturbed register reset only fields");
  chk_det_map: assert property (i_det_done && i_variant_det && !i_reg_reset
    |=> o_iin_limit == lim_of($past(i_det_src)))
    else $error("detected source loaded wrong limit");
  chk_strap_map: assert property (i_det_done && !i_variant_det && !i_reg_reset
    && $stable(i_psel) && i_psel == $past(i_psel, 4)
    |=> o_iin_limit == ($past(i_psel) ? `CIP_LIM_500MA : `CIP_LIM_2400MA))
    else $error("strap variant loaded wrong limit");
  // Data may only move while the clock is low
  chk_oe_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data drive changed while clock high");
  chk_int_single: assert property (o_fault_int |=> !o_fault_int)
    else $error("fault interrupt longer than one cycle");
  chk_int_cause: assert property (o_fault_int |-> |$past(i_fault) || |$past(i_fault, 2))
    else $error("fault interrupt without a fault");
endmodule

// ---- cip_host.sv ----
// Purpose: Bus initiator model driving the serial clock and data.
// Assumes: Reads back the resolved wire; a released line reads high.
// Notes:   Each data bit holds the clock high 8 mclk and low 16, longer than the shortest phase the port accepts.
`timescale 1ns/10ps
module cip_host (
  input  wire logic i_mclk,
  input  wire logic i_sda,
  output      logic o_scl,
  output      logic o_sda
);
  // Idle bus: both lines released, clock stands still high
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // One timing step of 8 mclk; the edge's updates land before anything moves
  task automatic half();
    repeat (8) @(posedge i_mclk);
    #1;
  endtask
  // Start or repeated start: data falls while the clock is high
  task automatic start();
    o_sda = 1'b1;
    half();
    o_scl = 1'b1;
    half();
    o_sda = 1'b0;
    half();
    o_scl = 1'b0;
    half();
  endtask
  // Stop: data rises while the clock is high
  task automatic stop();
    o_sda = 1'b0;
    half();
    o_scl = 1'b1;
    half();
    o_sda = 1'b1;
    half();
  endtask
  // Data moves only in the low phase, so it never fakes a start or stop
  task automatic bit_io(input logic b, output logic r);
    o_sda = b;
    half();
    o_scl = 1'b1;
    half();
    r = i_sda;
    o_scl = 1'b0;
    half();
  endtask
  // Byte out, MSB first; ack is a low line in the ninth bit
  task automatic tx(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, r);
    ack = (r === 1'b0);
  endtask
  // Byte in; the last one is answered with a not-acknowledge
  task automatic rx(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      v[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule

// ---- testbench.sv ----
// Purpose: Self-checking bench for the charger register port.
// Assumes: Host model owns the bus; data line has a pull-up.
// Notes:   Detection, fault and reset inputs are driven directly.
`timescale 1ns/10ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
  logic                 mclk, rst, rrst, wdog, det, vdet, psel, scl, hsda, sda_o, oe, himp;
  logic                 fint, ok, ce;
  logic [1:0]           stat;
  logic [4:0]           flt, lim;
  logic [2:0]           therm;
  cip_pkg::cip_src_type src;
  int                   failures, compares, ints;
  // Open drain: low if anyone pulls, else the pull-up wins
  wire                  sda_w = hsda & (oe ? sda_o : 1'b1);
  // Expected limits in source code order
  logic [4:0]           lim_tab [7] = '{5'h04, 5'h17, 5'h04, 5'h09, 5'h13, 5'h14, 5'h17};

  cip_port i_cip_port (.i_mclk(mclk), .i_reset(rst), .i_ce(ce), .i_scl(scl), .i_sda(sda_w),
    .o_sda(sda_o), .o_sda_oe(oe), .i_reg_reset(rrst), .i_wdog_expire(wdog), .i_fault(flt),
    .i_therm_fault(therm), .i_det_done(det), .i_variant_det(vdet), .i_det_src(src),
    .i_psel(psel), .o_high_impedance_enable(himp), .o_stat_func(stat), .o_iin_limit(lim),
    .o_fault_int(fint));
  cip_host i_cip_host (.i_mclk(mclk), .i_sda(sda_w), .o_scl(scl), .o_sda(hsda));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Interrupt pulses seen so far
  always @(posedge mclk) if (fint === 1'b1) ints++;

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(2);
  endtask
  // Fault held three cycles so the latch surely sees it
  task automatic fault_on(input logic [4:0] v);
    flt = v;
    tick(3);
    flt = 5'h00;
    tick(2);
  endtask
  // Write burst; e is the expected ack of the last byte sent
  task automatic wr(input logic [7:0] idx, input logic [7:0] d[$], input logic e);
    logic a;
    i_cip_host.start();
    i_cip_host.tx(8'hD6, a);
    i_cip_host.tx(idx, a);
    foreach (d[i]) if (a) i_cip_host.tx(d[i], a);
    i_cip_host.stop();
    `CHK(a, e)
  endtask
  // Read burst compared byte by byte against e
  task automatic rd(input logic [7:0] idx, input logic [7:0] e[$]);
    logic [7:0] v;
    logic       a;
    i_cip_host.start();
    i_cip_host.tx(8'hD6, a);
    i_cip_host.tx(idx, a);
    i_cip_host.start();
    i_cip_host.tx(8'hD7, a);
    foreach (e[i]) begin
      i_cip_host.rx(i == e.size() - 1, v);
      `CHK(v, e[i])
    end
    i_cip_host.stop();
  endtask
  task automatic finish_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    {rrst, wdog, det, vdet} = 4'h0;
    ce = 1'b1;
    psel = 1'b1;
    flt = 5'h00;
    therm = 3'h5;
    src = cip_pkg::CIP_SRC_STD_PORT;
    tick(16);
    rst = 1'b0;
    tick(4);
    // Register access, bursts and refusals
    `CHK({himp, stat, lim}, 8'h17)
    wr(8'h00, {8'h85, 8'hA1}, 1'b1);
    `CHK({himp, stat, lim}, 8'h85)
    rd(8'h00, {8'h85, 8'hA1});
    wr(8'h0A, {8'h3C}, 1'b1);
    wr(8'h0C, {8'h11}, 1'b0);
    wr(8'h0B, {8'h66, 8'h77}, 1'b0);
    rd(8'h0A, {8'h3C, 8'h66, 8'hFF});
    i_cip_host.start();
    i_cip_host.tx(8'hD4, ok);
    i_cip_host.stop();
    `CHK(ok, 1'b0)
    $display("test registers done");
    // Latched faults, live thermistor bits, single interrupt
    fault_on(5'h01);
    fault_on(5'h02);
    `CHK(ints, 1)
    rd(8'h09, {8'h1D});
    rd(8'h09, {8'h05});
    fault_on(5'h04);
    `CHK(ints, 2)
    rd(8'h08, {8'h00, 8'h25, 8'h3C});
    rd(8'h09, {8'h25});
    therm = 3'h2;
    rd(8'h09, {8'h02});
    $display("test faults done");
    // Watchdog keeps all but high impedance; register reset restores all
    wr(8'h00, {8'hE3}, 1'b1);
    pulse(wdog);
    `CHK({himp, stat, lim}, 8'h63)
    // Clock enable low freezes state, so this reset pulse is lost
    ce = 1'b0;
    pulse(rrst);
    ce = 1'b1;
    `CHK({himp, stat, lim}, 8'h63)
    pulse(rrst);
    `CHK({himp, stat, lim}, 8'h17)
    rd(8'h00, {8'h17, 8'h00});
    $display("test resets done");
    // Automatic limit for every source, both variants, then host override
    vdet = 1'b1;
    for (int s = 0; s < 7; s++) begin
      src = cip_pkg::cip_src_type'(s);
      pulse(det);
      `CHK(lim, lim_tab[s])
    end
    vdet = 1'b0;
    for (int p = 0; p < 2; p++) begin
      psel = p[0];
      tick(6);
      pulse(det);
      `CHK(lim, p[0] ? 5'h04 : 5'h17)
    end
    wr(8'h00, {8'h0A}, 1'b1);
    `CHK(lim, 5'h0A)
    $display("test detection done");
    finish_test();
  end

  // Hang guard: a run this long counts as a mismatch
  initial begin
    repeat (90000) @(posedge mclk);
    failures++;
    finish_test();
  end
endmodule
bind cip_port cip_port_chk i_cip_port_chk (.*);
